/* design/fwc_ctrl.sv */
// Purpose: Write path control and status of the flash program/erase engine, APB slave.
// Assumes: Bank access strobes come from logic on I_CLK; I_BOOT_MODE is an asynchronous pin.
// Notes:   Register reads that trap answer with PSLVERR and a pulse on O_TRAP, data reads as zero.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
// How it works
// - Launch sets both bank active flags.
// - Protection programming also sets bank flags.
// - Busy bank: reads trap, writes ignored.
// - Flags clear at end/pause, return on resume.
// - Lockout traps register reads, blocks writes except pause requests outside protection runs.
// - Launch sets the lockout flag.
// - Lockout flag always readable; software polls it.
// - Fault register updates only once idle.
// - Test sector unwritable, visible only bootstrapping.
// - Mode arm cleared when operation ends.
// - Protection select cleared at completion.
// - Protection address outside window flags fault.
// - Sector wipe select cleared at completion.
// - Erase preprograms sectors automatically first.
// - Two word select cleared at completion.
// - Single word select cleared at completion.
// - Launch cleared at end/pause; zero ignored.
// - Launch refused on fault or pause.
// - Pause halts; erase pause allows programming.
module fwc_ctrl
  import fwc_pkg::*;
#(
  parameter int PROG_N  = PROG_CYCLES,
  parameter int PRE_N   = PRE_CYCLES,
  parameter int ERASE_N = ERASE_CYCLES
) (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [fwc_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  input  wire logic [3:0]                I_PSTRB,
  output logic                           O_PREADY,
  output logic [31:0]                    O_PRDATA,
  output logic                           O_PSLVERR,
  input  wire logic                      I_BOOT_MODE,
  input  wire logic                      I_BANK_RD,
  input  wire logic                      I_BANK_WR,
  input  wire logic                      I_BANK_ID,
  input  wire logic                      I_BANK_TEST,
  output logic                           O_BANK_GRANT,
  output logic                           O_TRAP,
  output logic                           O_TEST_VISIBLE,
  output logic                           O_PREPROG
);
  import fwc_pkg::*;

  // ---------------------------------------------------------------------------
  // Byte-lane merge
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  fwc_state_t        state_r, state_nxt;
  logic              launch_r, pause_r, word_r, dword_r, wipe_r, prot_r, arm_r;
  logic              launch_nxt, pause_nxt, word_nxt, dword_nxt, wipe_nxt, prot_nxt, arm_nxt;
  logic [1:0]        bank_active_r;
  logic              lock_r, boot_r, seq_r, seq_nxt;
  logic [SECT_W-1:0] sector_r;
  logic [31:0]       payload0_r, payload1_r, target_r;
  logic              pready_r, pslverr_r, grant_r, trap_r, pre_r;
  logic [31:0]       prdata_r;
  logic [2:0]        boot_sync_r;
  logic              start1, start2, eng_done, eng2_done, eng_pre;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic sel_low, sel_hi, sel_sect, sel_p0, sel_p1, sel_tgt, sel_flt, sel_none;
  always_comb begin
    {sel_low, sel_hi, sel_sect, sel_p0, sel_p1, sel_tgt, sel_flt, sel_none} = 8'h00;
    if (I_PADDR == ADDR_CTRL_LOW) begin
      sel_low = 1'b1;
    end else if (I_PADDR == ADDR_CTRL_HI) begin
      sel_hi = 1'b1;
    end else if (I_PADDR == ADDR_SECTOR) begin
      sel_sect = 1'b1;
    end else if (I_PADDR == ADDR_PAYLOAD0) begin
      sel_p0 = 1'b1;
    end else if (I_PADDR == ADDR_PAYLOAD1) begin
      sel_p1 = 1'b1;
    end else if (I_PADDR == ADDR_TARGET) begin
      sel_tgt = 1'b1;
    end else if (I_PADDR == ADDR_FAULT) begin
      sel_flt = 1'b1;
    end else begin
      sel_none = 1'b1;
    end
  end

  wire        acc       = I_PSEL & I_PENABLE & pready_r;
  wire        wr_acc    = acc & I_PWRITE;
  wire        rd_acc    = acc & ~I_PWRITE;
  // The lockout flag stays readable through the low half at all times.
  wire        locked_rd = lock_r & ~sel_low & ~sel_none;
  wire        wr_ok     = wr_acc & ~lock_r;
  wire [31:0] wd        = I_PWDATA;
  wire        hi_wr     = wr_ok & sel_hi & I_PSTRB[1];
  wire        lo_strb   = wr_ok & sel_hi & I_PSTRB[0];
  wire        fault_err = seq_r;
  wire        wr_prog   = wd[B_WORD] | wd[B_DWORD];
  wire        prot_bad  = (target_r[23:0] < PROT_LO) | (target_r[23:0] > PROT_HI);
  wire [15:0] low_view  = {9'h000, bank_active_r, lock_r, 4'h0};
  wire [15:0] hi_view   = {launch_r, pause_r, word_r, dword_r, wipe_r, 2'b00, prot_r,
                           arm_r, 7'h00};
  wire [31:0] flt_view  = {30'h0, seq_r, fault_err};
  // A launch is taken only when no fault stands and the pause bit is written low.
  wire        launch_rq = hi_wr & wd[B_LAUNCH] & ~fault_err & ~wd[B_PAUSE];
  // Pausing is still taken while locked, except in a protection run, otherwise a running job could never be halted.
  wire        pause_rq  = wr_acc & sel_hi & I_PSTRB[1] & wd[B_PAUSE] & ~prot_r;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = BAD_DATA;
    if (locked_rd) begin
      rd_mux = BAD_DATA;
    end else if (sel_low) begin
      rd_mux = {16'h0000, low_view};
    end else if (sel_hi) begin
      rd_mux = {16'h0000, hi_view};
    end else if (sel_sect) begin
      rd_mux = {20'h00000, sector_r};
    end else if (sel_p0) begin
      rd_mux = payload0_r;
    end else if (sel_p1) begin
      rd_mux = payload1_r;
    end else if (sel_tgt) begin
      rd_mux = target_r;
    end else if (sel_flt) begin
      rd_mux = flt_view;
    end
  end

  // ---------------------------------------------------------------------------
  // Operation sequencing
  // ---------------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    launch_nxt = launch_r;
    pause_nxt  = hi_wr ? wd[B_PAUSE] : pause_r;
    word_nxt   = hi_wr ? wd[B_WORD] : word_r;
    dword_nxt  = hi_wr ? wd[B_DWORD] : dword_r;
    wipe_nxt   = hi_wr ? wd[B_WIPE] : wipe_r;
    prot_nxt   = lo_strb ? wd[B_PROT] : prot_r;
    arm_nxt    = lo_strb ? wd[B_ARM] : arm_r;
    seq_nxt    = (wr_ok & sel_flt & I_PSTRB[0]) ? wd[B_SEQ] : seq_r;
    start1     = 1'b0;
    start2     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (launch_rq) begin
          state_nxt  = ST_RUN;
          launch_nxt = 1'b1; // Writing zero to the launch bit does nothing.
          start1     = 1'b1;
        end
      end
      ST_RUN: begin
        if (eng_done) begin
          state_nxt  = ST_IDLE;
          launch_nxt = 1'b0;
          pause_nxt  = 1'b0;
          word_nxt   = 1'b0;
          dword_nxt  = 1'b0;
          wipe_nxt   = 1'b0;
          prot_nxt   = 1'b0;
          arm_nxt    = 1'b0;
          seq_nxt    = seq_r | (prot_r & prot_bad);
        end else if (pause_rq) begin
          state_nxt  = wipe_r ? ST_ESUSP : ST_PSUSP;
          launch_nxt = 1'b0;
          pause_nxt  = 1'b1;
        end
      end
      ST_PSUSP: begin
        // Only the suspended program may be resumed here.
        if (launch_rq & ((wd[B_WORD] & word_r) | (wd[B_DWORD] & dword_r))) begin
          state_nxt  = ST_RUN;
          launch_nxt = 1'b1;
        end
      end
      ST_ESUSP: begin
        if (launch_rq & wd[B_WIPE]) begin
          state_nxt  = ST_RUN;
          launch_nxt = 1'b1;
        end else if (launch_rq & wr_prog) begin
          state_nxt  = ST_NEST;
          launch_nxt = 1'b1;
          start2     = 1'b1;
        end
      end
      ST_NEST: begin
        // A program inside an erase pause cannot itself be paused.
        if (eng2_done) begin
          state_nxt  = ST_ESUSP;
          launch_nxt = 1'b0;
          word_nxt   = 1'b0;
          dword_nxt  = 1'b0;
          wipe_nxt   = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  wire run_nxt = (state_nxt == ST_RUN) | (state_nxt == ST_NEST);

  fwc_op_timer #(
    .PROG_N  (PROG_N),
    .PRE_N   (PRE_N),
    .ERASE_N (ERASE_N)
  ) u_main_op (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_start   (start1),
    .i_erase   (wipe_nxt),
    .i_hold    (state_r != ST_RUN),
    .o_done    (eng_done),
    .o_preprog (eng_pre)
  );

  fwc_op_timer #(
    .PROG_N  (PROG_N),
    .PRE_N   (PRE_N),
    .ERASE_N (ERASE_N)
  ) u_nest_op (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_start   (start2),
    .i_erase   (1'b0),
    .i_hold    (state_r != ST_NEST),
    .o_done    (eng2_done),
    .o_preprog ()
  );

  // ---------------------------------------------------------------------------
  // Bank access screening
  // ---------------------------------------------------------------------------
  wire bank_busy  = bank_active_r[I_BANK_ID];
  // The test sector never takes a user write and is readable only in bootstrap.
  wire test_ok    = I_BANK_TEST ? (I_BANK_RD & boot_r) : 1'b1;
  wire grant_nxt  = (I_BANK_RD | I_BANK_WR) & ~bank_busy & test_ok;
  wire trap_nxt   = (I_BANK_RD & bank_busy) | (rd_acc & locked_rd);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r       <= ST_IDLE;
      {launch_r, pause_r, word_r, dword_r, wipe_r, prot_r, arm_r} <= 7'h00;
      bank_active_r <= 2'b00;
      lock_r        <= 1'b0;
      seq_r         <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      {launch_r, pause_r, word_r, dword_r} <= {launch_nxt, pause_nxt, word_nxt, dword_nxt};
      {wipe_r, prot_r, arm_r} <= {wipe_nxt, prot_nxt, arm_nxt};
      bank_active_r <= {2{run_nxt}};
      lock_r        <= run_nxt;
      seq_r         <= seq_nxt;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sector_r   <= '0;
      payload0_r <= RST_WORD;
      payload1_r <= RST_WORD;
      target_r   <= RST_WORD;
    end else begin
      sector_r   <= (wr_ok & sel_sect) ? SECT_W'(merge(32'(sector_r), wd, I_PSTRB))
                                        : sector_r;
      payload0_r <= (wr_ok & sel_p0) ? merge(payload0_r, wd, I_PSTRB) : payload0_r;
      payload1_r <= (wr_ok & sel_p1) ? merge(payload1_r, wd, I_PSTRB) : payload1_r;
      target_r   <= (wr_ok & sel_tgt) ? merge(target_r, wd, I_PSTRB) : target_r;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= BAD_DATA;
      grant_r   <= 1'b0;
      trap_r    <= 1'b0;
      pre_r     <= 1'b0;
    end else begin
      pready_r  <= I_PSEL & I_PENABLE & ~pready_r;
      pslverr_r <= I_PSEL & I_PENABLE & ~pready_r & (sel_none | (~I_PWRITE & locked_rd));
      prdata_r  <= (I_PSEL & ~I_PWRITE) ? rd_mux : BAD_DATA;
      grant_r   <= grant_nxt;
      trap_r    <= trap_nxt;
      pre_r     <= eng_pre & (state_r == ST_RUN);
    end
  end

  // Third and second stages must agree before the bootstrap level is believed.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      boot_sync_r <= 3'b000;
      boot_r      <= 1'b0;
    end else begin
      boot_sync_r <= {boot_sync_r[1:0], I_BOOT_MODE};
      boot_r      <= (boot_sync_r[2] == boot_sync_r[1]) ? boot_sync_r[1] : boot_r;
    end
  end

  assign O_PREADY       = pready_r;
  assign O_PRDATA       = prdata_r;
  assign O_PSLVERR      = pslverr_r;
  assign O_BANK_GRANT   = grant_r;
  assign O_TRAP         = trap_r;
  assign O_TEST_VISIBLE = boot_r;
  assign O_PREPROG      = pre_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_launch_sets_busy: assert property ((state_r == ST_IDLE) && launch_rq |=>
    bank_active_r == 2'b11 && lock_r && launch_r) else $error("launch did not set busy");
  a_prot_busy_set: assert property ((state_r == ST_IDLE) && launch_rq && wd[B_PROT]
    |=> ##1 bank_active_r == 2'b11) else $error("protection run not busy");
  a_busy_bank_trap: assert property (I_BANK_RD && bank_busy |=> O_TRAP && !O_BANK_GRANT)
    else $error("busy bank read not trapped");
  a_end_clears: assert property ((state_r == ST_RUN) && eng_done |=>
    bank_active_r == 2'b00 && !lock_r && !launch_r && !arm_r) else $error("end not cleared");
  a_lock_rd_trap: assert property (rd_acc && locked_rd |=> O_TRAP)
    else $error("locked read not trapped");
  a_lock_no_write: assert property (wr_acc && lock_r && sel_p0 |=> $stable(payload0_r))
    else $error("locked write took effect");
  a_fault_when_idle: assert property ($rose(seq_r) |-> bank_active_r == 2'b00)
    else $error("fault changed while busy");
  a_test_no_write: assert property (I_BANK_WR && I_BANK_TEST |=> !O_BANK_GRANT)
    else $error("test sector write granted");
  a_prot_window: assert property ((state_r == ST_RUN) && eng_done && prot_r && prot_bad
    |=> seq_r) else $error("protection address fault missed");
  a_refuse_fault: assert property ((state_r == ST_IDLE) && hi_wr && fault_err
    |=> !launch_r [*2]) else $error("launch taken with fault");
  a_pause_halts: assert property ((state_r == ST_RUN) && pause_rq && !eng_done
    |=> !launch_r && bank_active_r == 2'b00 && !lock_r) else $error("pause did not halt");

  c_word_done: cover property ((state_r == ST_RUN) && word_r && eng_done);
  c_erase_pause: cover property (state_r == ST_ESUSP);
  c_nested_prog: cover property ((state_r == ST_NEST) && eng2_done);

endmodule : fwc_ctrl

/* design/fwc_op_timer.sv */
// Purpose: Stand-in for the program and erase engine timing, with erase preprogram phase.
// Assumes: Start restarts from zero; hold freezes the count for suspend.
// Notes:   Done is a one-cycle pulse; preprog is high during the preprogram phase.
`timescale 1ns/10ps
module fwc_op_timer
  import fwc_pkg::*;
#(
  parameter int PROG_N  = PROG_CYCLES,
  parameter int PRE_N   = PRE_CYCLES,
  parameter int ERASE_N = ERASE_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_erase,
  input  wire logic i_hold,
  output logic      o_done,
  output logic      o_preprog
);
  import fwc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;
  logic             pre_r;
  logic             done_r;
  wire  [CNT_W-1:0] last = pre_r ? CNT_W'(PRE_N - 1) :
                           (i_erase ? CNT_W'(ERASE_N - 1) : CNT_W'(PROG_N - 1));
  wire              step = run_r & ~i_hold;
  wire              fin  = step & (cnt_r == last);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      pre_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (i_start) begin
      cnt_r  <= '0;
      run_r  <= 1'b1;
      pre_r  <= i_erase; // Selected sectors are first driven to 0x00.
      done_r <= 1'b0;
    end else begin
      cnt_r  <= fin ? '0 : (step ? cnt_r + 1'b1 : cnt_r);
      pre_r  <= fin ? 1'b0 : pre_r;
      run_r  <= fin & ~pre_r ? 1'b0 : run_r;
      done_r <= fin & ~pre_r;
    end
  end

  assign o_done    = done_r;
  assign o_preprog = pre_r;

endmodule : fwc_op_timer

/* design/fwc_pkg.sv */
// Purpose: Shared constants and types for the flash write control and status block.
// Assumes: APB with 32-bit data; printed offsets are register indices, byte address = 4 * index.
// Notes:   Every 16-bit register sits in the low half of its word; upper bits read as zero.
package fwc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W       = 24;
  localparam logic [23:0] IDX_CTRL_LOW = 24'h0e0000;
  localparam logic [23:0] IDX_CTRL_HI  = 24'h0e0002;
  localparam logic [23:0] IDX_SECTOR   = 24'h0e0004;
  localparam logic [23:0] IDX_PAYLOAD0 = 24'h0e0008;
  localparam logic [23:0] IDX_PAYLOAD1 = 24'h0e000c;
  localparam logic [23:0] IDX_TARGET   = 24'h0e0010;
  localparam logic [23:0] IDX_FAULT    = 24'h0e0014;
  localparam logic [23:0] ADDR_CTRL_LOW = {IDX_CTRL_LOW[21:0], 2'b00};
  localparam logic [23:0] ADDR_CTRL_HI  = {IDX_CTRL_HI[21:0], 2'b00};
  localparam logic [23:0] ADDR_SECTOR   = {IDX_SECTOR[21:0], 2'b00};
  localparam logic [23:0] ADDR_PAYLOAD0 = {IDX_PAYLOAD0[21:0], 2'b00};
  localparam logic [23:0] ADDR_PAYLOAD1 = {IDX_PAYLOAD1[21:0], 2'b00};
  localparam logic [23:0] ADDR_TARGET   = {IDX_TARGET[21:0], 2'b00};
  localparam logic [23:0] ADDR_FAULT    = {IDX_FAULT[21:0], 2'b00};

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int B_BANK1  = 6;
  localparam int B_BANK0  = 5;
  localparam int B_LOCK   = 4;
  localparam int B_LAUNCH = 15;
  localparam int B_PAUSE  = 14;
  localparam int B_WORD   = 13;
  localparam int B_DWORD  = 12;
  localparam int B_WIPE   = 11;
  localparam int B_PROT   = 8;
  localparam int B_ARM    = 7;
  localparam int B_ERR    = 0;
  localparam int B_SEQ    = 1;
  localparam int SECT_W   = 12;
  localparam logic [15:0] RST_CTRL     = 16'h0000;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [31:0] BAD_DATA     = 32'h0000_0000;
  localparam logic [23:0] PROT_LO      = 24'h0edfb0;
  localparam logic [23:0] PROT_HI      = 24'h0edfbf;

  // ---------------------------------------------------------------------------
  // Timing counts (operation lengths are not given, plain defaults)
  // ---------------------------------------------------------------------------
  localparam int PROG_CYCLES  = 16;
  localparam int PRE_CYCLES   = 16;
  localparam int ERASE_CYCLES = 32;
  localparam int CNT_W        = 12;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PSUSP, ST_ESUSP, ST_NEST} fwc_state_t;

endpackage : fwc_pkg

/* test/fwc_ctrl_tb.sv */
// Purpose: Self-checking bench for the flash write control block over APB and bank strobes.
// Assumes: Short operation counts through parameters; one wait state on APB.
// Notes:   Expected values come from the bit layout in the package, not from the design.
`timescale 1ns/10ps
module test_fwc_ctrl;
  import fwc_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------------------
  logic        clk, rst, psel, pen, pwr, brd, bwr, bid, btest, boot;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] p0_m;
  logic [31:0] pq [$];
  logic [3:0]  pstrb;
  logic        pready, perr, grant, trap, tvis, preprog, err, gs, ts, ps;
  int          fails, checks, cyc;
  fwc_ctrl #(.PROG_N(40), .PRE_N(4), .ERASE_N(40)) fwc_ctrl_inst (
    .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(perr), .I_BOOT_MODE(boot), .I_BANK_RD(brd),
    .I_BANK_WR(bwr), .I_BANK_ID(bid), .I_BANK_TEST(btest), .O_BANK_GRANT(grant),
    .O_TRAP(trap), .O_TEST_VISIBLE(tvis), .O_PREPROG(preprog));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sticky monitors so one-cycle pulses are never missed.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (grant === 1'b1) gs <= 1'b1;
    if (trap === 1'b1) ts <= 1'b1;
    if (preprog === 1'b1) ps <= 1'b1;
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [23:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask : rchk
  task automatic bank(input logic r, input logic id, input logic t, input logic g, input logic tr);
    gs = 1'b0; ts = 1'b0;
    @(posedge clk);
    brd <= r; bwr <= ~r; bid <= id; btest <= t;
    @(posedge clk);
    brd <= 1'b0; bwr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, gs, ts}, {30'h0, g, tr});
  endtask : bank
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_CTRL_LOW, 32'h0);
      n = n + 1;
    end while (rd[B_LOCK] !== 1'b0 && n < 100);
    chk(rd, 32'h0);
  endtask : wait_idle
  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  logic [31:0] sel [2];
  logic        b;
  initial begin
    fails = 0; checks = 0; cyc = 0;
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 24'h0; pwdata = 32'h0;
    brd = 1'b0; bwr = 1'b0; bid = 1'b0; btest = 1'b0; boot = 1'b0;
    gs = 1'b0; ts = 1'b0; ps = 1'b0;
    pstrb = 4'hf;
    sel[0] = 32'h2000;
    sel[1] = 32'h1000;
    void'($urandom(32'h562e262b));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_CTRL_LOW, 32'h0, 1'b0);
    rchk(ADDR_CTRL_HI, 32'h0, 1'b0);
    rchk(24'h000100, 32'h0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      b = 1'($urandom);
      p0_m = $urandom;
      pq.push_back(p0_m);
      apb(1'b1, ADDR_PAYLOAD0, p0_m);
      apb(1'b1, ADDR_PAYLOAD1, $urandom);
      apb(1'b1, ADDR_TARGET, 32'h10000);
      apb(1'b1, ADDR_CTRL_HI, 32'h8080 | sel[k]);
      rchk(ADDR_CTRL_LOW, 32'h70, 1'b0);
      ts = 1'b0;
      rchk(ADDR_CTRL_HI, 32'h0, 1'b1);
      repeat (3) @(posedge clk);
      chk({31'h0, ts}, 32'h1);
      bank(1'b1, b, 1'b0, 1'b0, 1'b1);
      bank(1'b0, b, 1'b0, 1'b0, 1'b0);
      apb(1'b1, ADDR_PAYLOAD0, ~p0_m);
      wait_idle();
      rchk(ADDR_PAYLOAD0, pq.pop_front(), 1'b0);
      rchk(ADDR_CTRL_HI, 32'h0, 1'b0);
      bank(1'b1, b, 1'b0, 1'b1, 1'b0);
    end
    pstrb <= 4'h1;
    apb(1'b1, ADDR_PAYLOAD0, 32'h0);
    pstrb <= 4'hf;
    rchk(ADDR_PAYLOAD0, {p0_m[31:8], 8'h00}, 1'b0);
    apb(1'b1, ADDR_TARGET, 32'h0edfc0);
    apb(1'b1, ADDR_CTRL_HI, 32'h8100);
    rchk(ADDR_CTRL_LOW, 32'h70, 1'b0);
    wait_idle();
    rchk(ADDR_FAULT, 32'h3, 1'b0);
    apb(1'b1, ADDR_CTRL_HI, 32'ha080);
    rchk(ADDR_CTRL_LOW, 32'h0, 1'b0);
    apb(1'b1, ADDR_FAULT, 32'h0);
    rchk(ADDR_FAULT, 32'h0, 1'b0);
    apb(1'b1, ADDR_TARGET, 32'h0edfb0);
    apb(1'b1, ADDR_CTRL_HI, 32'h8100);
    wait_idle();
    rchk(ADDR_FAULT, 32'h0, 1'b0);
    apb(1'b1, ADDR_SECTOR, 32'h1);
    ps = 1'b0;
    apb(1'b1, ADDR_CTRL_HI, 32'h8880);
    apb(1'b1, ADDR_CTRL_HI, 32'h4880);
    chk({31'h0, ps}, 32'h1);
    rchk(ADDR_CTRL_LOW, 32'h0, 1'b0);
    apb(1'b1, ADDR_CTRL_HI, 32'ha080);
    rchk(ADDR_CTRL_LOW, 32'h70, 1'b0);
    wait_idle();
    rchk(ADDR_CTRL_HI, 32'h0880, 1'b0);
    apb(1'b1, ADDR_CTRL_HI, 32'h0880);
    apb(1'b1, ADDR_CTRL_HI, 32'h8880);
    rchk(ADDR_CTRL_LOW, 32'h70, 1'b0);
    wait_idle();
    rchk(ADDR_CTRL_HI, 32'h0, 1'b0);
    bank(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    bank(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    boot <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, tvis}, 32'h1);
    bank(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    bank(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    final_report();
  end
endmodule : test_fwc_ctrl
